// ### pkg/rar_pkg.sv
// Constants and types for the I2C alias remap block.
// Assumes APB with 32-bit data and one register per aligned word.
package rar_pkg;
    localparam int RAR_ADDR_W = 7;
    localparam int RAR_PADDR_W = 8;
    localparam int RAR_NUM_ALIAS = 2;
    localparam int RAR_NUM_PHYS = 3;
    // Register indices; byte address is four times the index
    localparam logic [5:0] RAR_IDX_PHYS5 = 6'h0D;
    localparam logic [5:0] RAR_IDX_PHYS6 = 6'h0E;
    localparam logic [5:0] RAR_IDX_PHYS7 = 6'h0F;
    localparam logic [5:0] RAR_IDX_ALIAS0 = 6'h10;
    localparam logic [5:0] RAR_IDX_ALIAS1 = 6'h11;
    localparam logic [7:0] RAR_SLOT_RESET = 8'h00;
    localparam int RAR_FIELD_LSB = 1;
    localparam int RAR_FIELD_MSB = 7;

    typedef logic [RAR_ADDR_W-1:0] rar_addr_t;

    typedef struct packed {
        logic hit;
        rar_addr_t addr;
    } rar_fwd_s;

    typedef struct packed {
        rar_addr_t slot7;
        rar_addr_t slot6;
        rar_addr_t slot5;
    } rar_phys_s;
endpackage : rar_pkg

// ### rtl/rar_alias_match.sv
// Alias comparator: finds the alias slot equal to a local address.
// Assumes slot values stable in the cycle they are compared.
`timescale 1ns/1ps
module rar_alias_match #(
    parameter int NUM = 2
) (
    input wire rar_pkg::rar_addr_t alias_addr [NUM],
    input wire rar_pkg::rar_addr_t phys_addr [NUM],
    input wire rar_pkg::rar_addr_t local_addr,
    output rar_pkg::rar_fwd_s result
);
    import rar_pkg::*;

    logic [NUM-1:0] hit_vec;

    // Refuse an empty slot set
    if (NUM < 1) begin : g_bad_num
        $error("NUM must be at least 1");
    end

    generate
        for (genvar i = 0; i < NUM; i++) begin : g_cmp
            // Zero alias disables the slot
            assign hit_vec[i] = (alias_addr[i] != '0) && (alias_addr[i] == local_addr); // R4
        end
    endgenerate

    // Lowest slot wins when two aliases are equal
    always_comb begin
        result = '0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                result.hit = 1'b1;
                result.addr = phys_addr[i]; // R2
            end
        end
    end
endmodule : rar_alias_match

// ### rtl/rar_remap.sv
// Alias remap registers with APB slave and registered address translation.
// Assumes lookup requests and slot 0/1 physical addresses come from
// logic on the same clock; those physical slots live elsewhere in the map.
//
// Behaviour
// (R1) Physical slots hold R/W 7-bit address, bits 7:1
// (R2) Alias match substitutes same-slot physical address
// (R3) Alias slots hold R/W 7-bit address, bits 7:1
// (R4) Zero alias never matches
// (R5) All slot registers reset to zero
// (R6) Slots at indices 0xD-0xF, 0x10, 0x11
// (R7) Bit 0 reads zero, writes ignored
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module rar_remap (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rar_pkg::RAR_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lookup_valid,
    input wire rar_pkg::rar_addr_t lookup_addr,
    input wire rar_pkg::rar_addr_t phys_addr_slot0,
    input wire rar_pkg::rar_addr_t phys_addr_slot1,
    output logic fwd_valid,
    output rar_pkg::rar_fwd_s fwd,
    output rar_pkg::rar_phys_s phys_upper
);
    import rar_pkg::*;

    rar_addr_t phys_addr_field_5;
    rar_addr_t phys_addr_field_6;
    rar_addr_t phys_addr_field_7;
    rar_addr_t alias_field_0;
    rar_addr_t alias_field_1;
    rar_addr_t alias_vec [RAR_NUM_ALIAS];
    rar_addr_t phys_vec [RAR_NUM_ALIAS];
    rar_fwd_s next_fwd;
    logic [5:0] idx;
    logic setup;
    logic wr_take;
    logic [31:0] next_rdata;
    logic next_err;

    function automatic logic idx_mapped(input logic [5:0] i, input logic [1:0] lo);
        idx_mapped = (lo == 2'h0) && (i >= RAR_IDX_PHYS5) && (i <= RAR_IDX_ALIAS1); // R6
    endfunction : idx_mapped

    function automatic logic [7:0] slot_byte(input rar_addr_t f);
        slot_byte = {f, 1'b0}; // R7
    endfunction : slot_byte

    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite && pstrb[0]
        && idx_mapped(idx, paddr[1:0]);

    always_comb begin
        next_rdata = '0;
        next_err = !idx_mapped(idx, paddr[1:0]);
        unique case (idx)
            RAR_IDX_PHYS5: next_rdata[7:0] = slot_byte(phys_addr_field_5); // R6
            RAR_IDX_PHYS6: next_rdata[7:0] = slot_byte(phys_addr_field_6); // R6
            RAR_IDX_PHYS7: next_rdata[7:0] = slot_byte(phys_addr_field_7); // R6
            RAR_IDX_ALIAS0: next_rdata[7:0] = slot_byte(alias_field_0); // R6
            RAR_IDX_ALIAS1: next_rdata[7:0] = slot_byte(alias_field_1); // R6
            default: next_rdata = '0;
        endcase
        if (next_err) begin
            next_rdata = '0;
        end
    end

    // Answer one cycle after setup: pready high in the first access cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && next_err;
            prdata <= (setup && !pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    // Slot storage; bit 0 of write data is dropped
    always_ff @(posedge clock) begin
        if (reset) begin
            phys_addr_field_5 <= RAR_SLOT_RESET[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R5
            phys_addr_field_6 <= RAR_SLOT_RESET[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R5
            phys_addr_field_7 <= RAR_SLOT_RESET[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R5
            alias_field_0 <= RAR_SLOT_RESET[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R5
            alias_field_1 <= RAR_SLOT_RESET[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R5
        end else if (wr_take) begin
            unique case (idx)
                RAR_IDX_PHYS5: phys_addr_field_5 <= pwdata[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R1
                RAR_IDX_PHYS6: phys_addr_field_6 <= pwdata[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R1
                RAR_IDX_PHYS7: phys_addr_field_7 <= pwdata[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R1
                RAR_IDX_ALIAS0: alias_field_0 <= pwdata[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R3
                RAR_IDX_ALIAS1: alias_field_1 <= pwdata[RAR_FIELD_MSB:RAR_FIELD_LSB]; // R3
                default: alias_field_1 <= alias_field_1;
            endcase
        end
    end

    assign alias_vec[0] = alias_field_0;
    assign alias_vec[1] = alias_field_1;
    assign phys_vec[0] = phys_addr_slot0;
    assign phys_vec[1] = phys_addr_slot1;

    rar_alias_match #(
        .NUM(RAR_NUM_ALIAS)
    ) u_match (
        .alias_addr(alias_vec),
        .phys_addr(phys_vec),
        .local_addr(lookup_addr),
        .result(next_fwd)
    );

    // Registered translation; a miss passes the local address unchanged
    always_ff @(posedge clock) begin
        if (reset) begin
            fwd_valid <= 1'b0;
            fwd <= '0;
        end else begin
            fwd_valid <= lookup_valid;
            fwd.hit <= lookup_valid && next_fwd.hit; // R2
            fwd.addr <= next_fwd.hit ? next_fwd.addr : lookup_addr; // R2
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            phys_upper <= '0;
        end else begin
            phys_upper <= '{slot7: phys_addr_field_7, slot6: phys_addr_field_6,
                slot5: phys_addr_field_5};
        end
    end

    property p_phys_write;
        @(posedge clock) disable iff (reset)
        (wr_take && idx == RAR_IDX_PHYS6) |=> (phys_addr_field_6 == $past(pwdata[7:1]));
    endproperty
    a_phys_write: assert property (p_phys_write) else $error("phys slot write lost"); // R1

    property p_remap;
        @(posedge clock) disable iff (reset)
        (lookup_valid && alias_field_1 != '0 && lookup_addr == alias_field_1
            && alias_field_0 != lookup_addr)
        |=> (fwd.hit && fwd_valid && fwd.addr == $past(phys_addr_slot1));
    endproperty
    a_remap: assert property (p_remap) else $error("alias not remapped"); // R2

    property p_alias_readback;
        @(posedge clock) disable iff (reset)
        (wr_take && idx == RAR_IDX_ALIAS0) ##1 (setup && !pwrite && idx == RAR_IDX_ALIAS0
            && !wr_take) |=> (prdata[7:1] == $past(pwdata[7:1], 2));
    endproperty
    a_alias_readback: assert property (p_alias_readback) else $error("alias readback"); // R3

    property p_zero_alias;
        @(posedge clock) disable iff (reset)
        (lookup_valid && lookup_addr == '0) |=> !fwd.hit;
    endproperty
    a_zero_alias: assert property (p_zero_alias) else $error("zero alias matched"); // R4

    property p_reset_zero;
        @(posedge clock) $past(reset) |-> (alias_field_0 == '0 && alias_field_1 == '0
            && phys_addr_field_5 == '0 && phys_addr_field_7 == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("slot not reset"); // R5

    property p_unmapped;
        @(posedge clock) disable iff (reset)
        (setup && (idx < RAR_IDX_PHYS5 || idx > RAR_IDX_ALIAS1)) |=> (pready && pslverr);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not flagged"); // R6

    property p_bit0_zero;
        @(posedge clock) disable iff (reset)
        pready |-> (prdata[0] == 1'b0);
    endproperty
    a_bit0_zero: assert property (p_bit0_zero) else $error("bit 0 nonzero"); // R7

    c_hit: cover property (@(posedge clock) disable iff (reset) fwd_valid && fwd.hit);
    c_write: cover property (@(posedge clock) disable iff (reset) wr_take);
    c_err: cover property (@(posedge clock) disable iff (reset) pready && pslverr);
endmodule : rar_remap

// ### verification/rar_partner.sv
// Local I2C controller model: presents one address per lookup.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/1ps
module rar_partner (
    input wire logic clock,
    output logic lookup_valid,
    output rar_pkg::rar_addr_t lookup_addr
);
    import rar_pkg::*;
    initial begin
        lookup_valid = 1'b0;
        lookup_addr = 7'h00;
    end
    task automatic send(input rar_addr_t a);
        @(posedge clock);
        lookup_valid <= 1'b1;
        lookup_addr <= a;
        @(posedge clock);
        lookup_valid <= 1'b0;
        // Released address shows the inverse, not the last value
        lookup_addr <= ~a;
    endtask : send
endmodule : rar_partner

// ### verification/tb.sv
// Self-checking bench for the alias remap block.
// Assumes rar_partner drives the lookup side; APB master is local.
`timescale 1ns/1ps
module tb;
    import rar_pkg::*;
    logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, lookup_valid, fwd_valid;
    rar_addr_t lookup_addr, a, phys_addr_slot0 = 7'h11, phys_addr_slot1 = 7'h22;
    rar_fwd_s fwd;
    rar_phys_s phys_upper;
    logic [7:0] exp [5] = '{default: 8'h00};
    int mismatches = 0, comparisons = 0, seed = 32;
    always #2 clock = ~clock;
    rar_remap rar_remap_inst (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .lookup_valid, .lookup_addr, .phys_addr_slot0,
        .phys_addr_slot1, .fwd_valid, .fwd, .phys_upper);
    rar_partner rar_partner_inst (.clock, .lookup_valid, .lookup_addr);
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, want);
        end
    endtask : chk
    function automatic logic [7:0] ra(input int i);
        return {RAR_IDX_PHYS5 + 6'(i), 2'b00};
    endfunction : ra
    function automatic rar_fwd_s exp_fwd(input rar_addr_t x);
        if (x != 0 && x == exp[3][7:1]) return {1'b1, phys_addr_slot0};
        if (x != 0 && x == exp[4][7:1]) return {1'b1, phys_addr_slot1};
        return {1'b0, x};
    endfunction : exp_fwd
    // Keep holds psel so the next call's setup follows at once
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
        input bit keep = 1'b0);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            @(posedge clock);
        end
        chk(n, 0, "ready latency");
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
            @(posedge clock);
        end
    endtask : apb
    task automatic rdc(input int i);
        apb(1'b0, ra(i), 32'h0);
        chk(rd, {24'h0, exp[i]}, "read");
        chk(32'(err), 0, "read err");
    endtask : rdc
    task automatic look(input rar_addr_t x);
        rar_partner_inst.send(x);
        @(posedge clock);
        chk(32'(fwd_valid), 1, "fwd valid");
        chk(32'(fwd), 32'(exp_fwd(x)), "fwd");
    endtask : look
    initial begin
        #40000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 5; i++) rdc(i);
        for (int k = 0; k < 4; k++) begin
            phys_addr_slot0 <= 7'($random(seed));
            phys_addr_slot1 <= 7'($random(seed));
            for (int i = 0; i < 5; i++) begin
                d = $random(seed) | 32'h1;
                apb(1'b1, ra(i), k == 3 && i == 4 ? {24'h0, exp[3] | 8'h01} : d);
                exp[i] = k == 3 && i == 4 ? exp[3] : d[7:0] & 8'hFE;
            end
            for (int i = 0; i < 5; i++) rdc(i);
            chk(32'(phys_upper), 32'({exp[2][7:1], exp[1][7:1], exp[0][7:1]}), "phys");
            for (int j = 0; j < 9; j++) begin
                a = j % 3 == 0 ? exp[3][7:1] : j % 3 == 1 ? exp[4][7:1] : 7'($random(seed));
                look(a);
            end
        end
        pstrb <= 4'hE;
        apb(1'b1, ra(0), 32'hFF);
        pstrb <= 4'hF;
        rdc(0);
        apb(1'b0, 8'h48, 32'h0);
        chk(32'({rd[0], err}), 32'h0000_0001, "unmapped");
        chk(rd, 32'h0000_0000, "unmapped data");
        apb(1'b0, 8'h35, 32'h0);
        chk(32'(err), 1, "misaligned");
        // Write then read back with no idle cycle between
        apb(1'b1, ra(3), 32'h0000_005A, 1'b1);
        exp[3] = 8'h5A;
        rdc(3);
        apb(1'b1, ra(3), 32'h1);
        exp[3] = 8'h00;
        rdc(3);
        look(7'h00);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        exp = '{default: 8'h00};
        for (int i = 0; i < 5; i++) rdc(i);
        look(7'h00);
        summarize();
    end
endmodule : tb
